/* mthd_detector.sv */
// Magnetic threshold event detector with its register port and interrupt routing
//
// Overview of operation
// - Event-active bit set when combination true
// - Source captures live event, or holds latched
// - Axis event flag shows detection per axis
// - Polarity flag: zero positive, one negative
// - Disabled axis reads zero event and polarity
// - Thresholds are unsigned 15-bit, 0.1 uT steps
// - Threshold split into high and low bytes
// - Offset-corrected data compared unless raw selected
// - Debounce mode one clears counter on miss
// - Debounce mode zero decrements counter on miss
// - Eight-bit count sets required qualifying samples
// - Event flag set when counter reaches count
// - Counter saturates at programmed count
// - Counter steps once per output sample
// - Hybrid mode halves rate, doubling step
// - Latch holds flag until source read
// - AND of below, or OR of above
// - Enabled flag routed to pin one or two
`timescale 1ns/1ps
`include "mthd_defines.svh"

module mthd_detector (
  input  wire logic                                  CLK,
  input  wire logic                                  RESET,
  input  wire logic [7:0]                            REG_ADDR,
  input  wire logic [7:0]                            REG_WDATA,
  input  wire logic                                  REG_WR,
  input  wire logic                                  REG_RD,
  output logic      [7:0]                            REG_RDATA,
  input  wire logic                                  SAMPLE_STROBE,
  input  wire logic [`MTHD_AXES-1:0][`MTHD_MAG_W-1:0] MAG_SAMPLE,
  input  wire logic [`MTHD_AXES-1:0][`MTHD_MAG_W-1:0] MAG_OFFSET,
  input  wire logic                                  RAW_OUTPUT,
  input  wire logic [1:0]                            SENSOR_MODE,
  input  wire mthd_pkg::mthd_cfg_type                CFG,
  input  wire logic                                  IRQ_ONE_OTHER,
  input  wire logic                                  IRQ_TWO_OTHER,
  output logic                                       IRQ_PIN_ONE,
  output logic                                       IRQ_PIN_TWO,
  output logic                                       EVENT_ACTIVE_FLAG
);

  logic [6:0]                   ths_hi_ff [`MTHD_AXES];
  logic [7:0]                   ths_lo_ff [`MTHD_AXES];
  logic                         clr_mode_ff;
  logic [7:0]                   count_ff;
  logic                         phase_ff;
  logic [7:0]                   rdata_ff;
  logic                         irq_one_ff;
  logic                         irq_two_ff;
  mthd_pkg::mthd_src_type       src_ff;
  mthd_pkg::mthd_src_type       nxt_src;
  mthd_pkg::mthd_src_type       src_view;
  mthd_pkg::mthd_axis_res_type  res [`MTHD_AXES];
  logic [`MTHD_AXES-1:0]        axis_evt;
  logic [`MTHD_AXES-1:0]        axis_neg;
  logic                         cond;
  logic                         step;
  logic                         trig;
  logic                         hold_latched;
  logic                         src_rd;
  logic [7:0]                   cnt;

  // Per-axis threshold registers and comparators
  generate
    for (genvar i = 0; i < `MTHD_AXES; i++)
    begin : g_axis
      logic [7:0] hi_addr;
      logic [7:0] lo_addr;

      assign hi_addr = `MTHD_ADDR_X_HI + 8'(2 * i);
      assign lo_addr = `MTHD_ADDR_X_LO + 8'(2 * i);

      always_ff @(posedge CLK)
      begin
        if (RESET)
        begin
          ths_hi_ff[i] <= `MTHD_RST_HI;
          ths_lo_ff[i] <= `MTHD_RST_BYTE;
        end
        else if (REG_WR)
        begin
          if (REG_ADDR == hi_addr)
            ths_hi_ff[i] <= REG_WDATA[`MTHD_HI_MSB:0];
          if (REG_ADDR == lo_addr)
            ths_lo_ff[i] <= REG_WDATA;
        end
      end

      mthd_axis_cmp u_cmp (
        .sample    (MAG_SAMPLE[i]),
        .offset    (MAG_OFFSET[i]),
        .raw_mode  (RAW_OUTPUT),
        .threshold ({ths_hi_ff[i], ths_lo_ff[i]}),
        .res       (res[i])
      );

      // Axis takes part only while its enable is set
      assign axis_evt[i] = CFG.axis_en[i] &&
                           (CFG.or_sel ? res[i].above : res[i].below);
      assign axis_neg[i] = res[i].neg;
    end
  endgenerate

  // Debounce mode bit lives in the X high byte, count in its own register
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      clr_mode_ff <= 1'b0;
      count_ff    <= `MTHD_RST_CNT;
    end
    else if (REG_WR)
    begin
      if (REG_ADDR == `MTHD_ADDR_X_HI)
        clr_mode_ff <= REG_WDATA[`MTHD_CLR_MODE_BIT];
      if (REG_ADDR == `MTHD_ADDR_COUNT)
        count_ff <= REG_WDATA;
    end
  end

  // AND of enabled below-flags, or OR of enabled above-flags
  assign cond = CFG.or_sel ? |axis_evt
                           : (|CFG.axis_en) && &(axis_evt | ~CFG.axis_en);

  // Hybrid mode: every second system sample carries magnetic data
  always_ff @(posedge CLK)
  begin
    if (RESET)
      phase_ff <= 1'b0;
    else if (SENSOR_MODE != `MTHD_MODE_HYB)
      phase_ff <= 1'b0;
    else if (SAMPLE_STROBE)
      phase_ff <= ~phase_ff;
  end

  assign step = SAMPLE_STROBE &&
                ((SENSOR_MODE == `MTHD_MODE_MAG) ||
                 ((SENSOR_MODE == `MTHD_MODE_HYB) && phase_ff));

  mthd_debounce u_debounce (
    .clk        (CLK),
    .reset      (RESET),
    .step       (step),
    .cond       (cond),
    .clear_mode (clr_mode_ff),
    .limit      (count_ff),
    .cnt_ff     (cnt),
    .trig       (trig)
  );

  // Source register: capture on trigger, latched events survive until read
  assign src_rd       = REG_RD && (REG_ADDR == `MTHD_ADDR_SRC);
  assign hold_latched = CFG.latch_en && src_ff.active && !src_rd;

  always_comb
  begin
    nxt_src = src_ff;
    if (step && trig && !hold_latched)
    begin
      nxt_src.active = 1'b1;
      nxt_src.rsvd   = 1'b0;
      nxt_src.x_evt  = axis_evt[0];
      nxt_src.x_neg  = axis_evt[0] && axis_neg[0];
      nxt_src.y_evt  = axis_evt[1];
      nxt_src.y_neg  = axis_evt[1] && axis_neg[1];
      nxt_src.z_evt  = axis_evt[2];
      nxt_src.z_neg  = axis_evt[2] && axis_neg[2];
    end
    else if (CFG.latch_en ? src_rd : step)
      nxt_src = '0;
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
      src_ff <= '0;
    else
      src_ff <= nxt_src;
  end

  // Disabled axes always read as zero
  always_comb
  begin
    src_view       = src_ff;
    src_view.x_evt = src_ff.x_evt && CFG.axis_en[0];
    src_view.x_neg = src_ff.x_neg && CFG.axis_en[0];
    src_view.y_evt = src_ff.y_evt && CFG.axis_en[1];
    src_view.y_neg = src_ff.y_neg && CFG.axis_en[1];
    src_view.z_evt = src_ff.z_evt && CFG.axis_en[2];
    src_view.z_neg = src_ff.z_neg && CFG.axis_en[2];
  end

  // Read data is registered; unmapped addresses read zero
  always_ff @(posedge CLK)
  begin
    if (RESET)
      rdata_ff <= `MTHD_RST_BYTE;
    else if (REG_RD)
    begin
      unique case (REG_ADDR)
        `MTHD_ADDR_SRC:   rdata_ff <= src_view;
        `MTHD_ADDR_X_HI:  rdata_ff <= {clr_mode_ff, ths_hi_ff[0]};
        `MTHD_ADDR_X_LO:  rdata_ff <= ths_lo_ff[0];
        `MTHD_ADDR_Y_HI:  rdata_ff <= {1'b0, ths_hi_ff[1]};
        `MTHD_ADDR_Y_LO:  rdata_ff <= ths_lo_ff[1];
        `MTHD_ADDR_Z_HI:  rdata_ff <= {1'b0, ths_hi_ff[2]};
        `MTHD_ADDR_Z_LO:  rdata_ff <= ths_lo_ff[2];
        `MTHD_ADDR_COUNT: rdata_ff <= count_ff;
        default:          rdata_ff <= `MTHD_RST_BYTE;
      endcase
    end
  end

  // Interrupt routing, OR'd with the other sources of each pin
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      irq_one_ff <= 1'b0;
      irq_two_ff <= 1'b0;
    end
    else
    begin
      irq_one_ff <= IRQ_ONE_OTHER || (CFG.int_en && CFG.int_route && nxt_src.active);
      irq_two_ff <= IRQ_TWO_OTHER || (CFG.int_en && !CFG.int_route && nxt_src.active);
    end
  end

  assign REG_RDATA         = rdata_ff;
  assign IRQ_PIN_ONE       = irq_one_ff;
  assign IRQ_PIN_TWO       = irq_two_ff;
  assign EVENT_ACTIVE_FLAG = src_ff.active;

  default clocking cb @(posedge CLK);
  endclocking

  default disable iff (RESET);

  sequence s_qualify;
    step && cond;
  endsequence

  sequence s_miss;
    step && !cond;
  endsequence

  sequence s_latched_flag;
    CFG.latch_en && src_ff.active && !src_rd;
  endsequence

  sequence s_capture;
    step && trig && !hold_latched;
  endsequence

  chk_count_incr: assert property (
    s_qualify and (cnt < count_ff) |=> cnt == $past(cnt) + `MTHD_CNT_ONE)
    else $error("debounce counter did not advance on qualifying sample");

  chk_count_sat: assert property (
    s_qualify and (cnt >= count_ff) |=> cnt == $past(count_ff))
    else $error("debounce counter passed the programmed count");

  chk_count_clear: assert property (
    s_miss and clr_mode_ff |=> cnt == `MTHD_RST_CNT)
    else $error("debounce counter not cleared on miss");

  chk_count_decr: assert property (
    s_miss and !clr_mode_ff && (cnt != `MTHD_RST_CNT) |=> cnt == $past(cnt) - `MTHD_CNT_ONE)
    else $error("debounce counter not decremented on miss");

  chk_count_idle: assert property (
    !step |=> cnt == $past(cnt))
    else $error("debounce counter moved without an output sample");

  chk_flag_reach: assert property (
    s_qualify and ({1'b0, cnt} + 9'h001 >= {1'b0, count_ff}) and !hold_latched
    |=> src_ff.active)
    else $error("event flag not set when count reached");

  chk_zero_count: assert property (
    s_qualify and (count_ff == `MTHD_RST_CNT) |=> src_ff.active)
    else $error("zero count did not trigger on first sample");

  chk_latch_hold: assert property (
    s_latched_flag |=> src_ff.active && $stable(src_ff))
    else $error("latched source changed before it was read");

  chk_live_follow: assert property (
    s_miss and !CFG.latch_en |=> !src_ff.active)
    else $error("live event flag stayed set after condition dropped");

  chk_read_clear: assert property (
    CFG.latch_en && src_rd && !(step && trig) |=> src_ff == '0)
    else $error("latched source not cleared by read");

  chk_mask_zero: assert property (
    !CFG.axis_en[0] |-> !src_view.x_evt && !src_view.x_neg)
    else $error("disabled X axis reads nonzero flags");

  chk_irq_one: assert property (
    CFG.int_en && CFG.int_route && src_ff.active && $stable(CFG) |-> IRQ_PIN_ONE)
    else $error("event flag not routed to interrupt pin one");

  chk_irq_two: assert property (
    CFG.int_en && !CFG.int_route && src_ff.active && $stable(CFG) |-> IRQ_PIN_TWO)
    else $error("event flag not routed to interrupt pin two");

  chk_hybrid_skip: assert property (
    (SENSOR_MODE == `MTHD_MODE_HYB) && step |=>
      ((SENSOR_MODE == `MTHD_MODE_HYB) && SAMPLE_STROBE) |-> !step)
    else $error("hybrid mode stepped on consecutive strobes");

  chk_src_axes: assert property (
    s_capture |=> src_ff.x_evt == $past(axis_evt[0]))
    else $error("X event flag not captured with the event");

  chk_src_polarity: assert property (
    s_capture and axis_evt[0] |=> src_ff.x_neg == $past(axis_neg[0]))
    else $error("X polarity flag does not match the sample sign");

  chk_active_cause: assert property (
    src_ff.active |-> src_ff.x_evt || src_ff.y_evt || src_ff.z_evt)
    else $error("event active without any axis event");

  chk_hi_write: assert property (
    REG_WR && (REG_ADDR == `MTHD_ADDR_Y_HI) |=> ths_hi_ff[1] == $past(REG_WDATA[`MTHD_HI_MSB:0]))
    else $error("threshold high byte not stored");

  chk_count_read: assert property (
    REG_RD && (REG_ADDR == `MTHD_ADDR_COUNT) |=> REG_RDATA == $past(count_ff))
    else $error("debounce count register read back wrong");

  chk_mag_step: assert property (
    SAMPLE_STROBE && (SENSOR_MODE == `MTHD_MODE_MAG) |-> step)
    else $error("magnetometer-only mode skipped an output sample");

  chk_irq_quiet: assert property (
    !CFG.int_en && !IRQ_ONE_OTHER && !IRQ_TWO_OTHER |=> !IRQ_PIN_ONE && !IRQ_PIN_TWO)
    else $error("interrupt pin raised while threshold interrupt disabled");

endmodule : mthd_detector

/* mthd_defines.svh */
// Register offsets, reset values and mode codes of the magnetic threshold detector
`ifndef MTHD_DEFINES_SVH
`define MTHD_DEFINES_SVH

`define MTHD_ADDR_SRC      8'h53
`define MTHD_ADDR_X_HI     8'h54
`define MTHD_ADDR_X_LO     8'h55
`define MTHD_ADDR_Y_HI     8'h56
`define MTHD_ADDR_Y_LO     8'h57
`define MTHD_ADDR_Z_HI     8'h58
`define MTHD_ADDR_Z_LO     8'h59
`define MTHD_ADDR_COUNT    8'h5A

`define MTHD_RST_BYTE      8'h00
`define MTHD_RST_HI        7'h00
`define MTHD_RST_CNT       8'h00
`define MTHD_CNT_ONE       8'h01
`define MTHD_CLR_MODE_BIT  7
`define MTHD_HI_MSB        6

`define MTHD_MODE_MAG      2'h1
`define MTHD_MODE_HYB      2'h3

`define MTHD_AXES          3
`define MTHD_THS_W         15
`define MTHD_MAG_W         16
`define MTHD_CORR_ZERO     17'h00000

`endif

/* mthd_pkg.sv */
// Types shared by the magnetic threshold detector modules
package mthd_pkg;

  typedef struct packed {
    logic active;
    logic rsvd;
    logic z_evt;
    logic z_neg;
    logic y_evt;
    logic y_neg;
    logic x_evt;
    logic x_neg;
  } mthd_src_type;

  typedef struct packed {
    logic above;
    logic below;
    logic neg;
  } mthd_axis_res_type;

  typedef struct packed {
    logic       latch_en;
    logic       or_sel;
    logic [2:0] axis_en;
    logic       int_en;
    logic       int_route;
  } mthd_cfg_type;

endpackage : mthd_pkg

/* mthd_axis_cmp.sv */
// Offset correction and threshold comparison for one axis
`timescale 1ns/1ps
`include "mthd_defines.svh"

module mthd_axis_cmp (
  input  wire logic [`MTHD_MAG_W-1:0]       sample,
  input  wire logic [`MTHD_MAG_W-1:0]       offset,
  input  wire logic                         raw_mode,
  input  wire logic [`MTHD_THS_W-1:0]       threshold,
  output mthd_pkg::mthd_axis_res_type       res
);

  logic [`MTHD_MAG_W:0] sample_ext;
  logic [`MTHD_MAG_W:0] offset_ext;
  logic [`MTHD_MAG_W:0] corr;
  logic [`MTHD_MAG_W:0] mag;
  logic [`MTHD_MAG_W:0] ths_ext;

  assign sample_ext = {sample[`MTHD_MAG_W-1], sample};
  assign offset_ext = {offset[`MTHD_MAG_W-1], offset};
  // Offset-corrected data unless raw output is selected
  assign corr       = raw_mode ? sample_ext : sample_ext - offset_ext;
  assign mag        = corr[`MTHD_MAG_W] ? `MTHD_CORR_ZERO - corr : corr;
  assign ths_ext    = {2'h0, threshold};

  always_comb
  begin
    res.above = mag >= ths_ext;
    res.below = mag <= ths_ext;
    res.neg   = corr[`MTHD_MAG_W];
  end

endmodule : mthd_axis_cmp

/* mthd_debounce.sv */
// Debounce counter of the threshold event condition
`timescale 1ns/1ps
`include "mthd_defines.svh"

module mthd_debounce (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       step,
  input  wire logic       cond,
  input  wire logic       clear_mode,
  input  wire logic [7:0] limit,
  output logic      [7:0] cnt_ff,
  output logic            trig
);

  logic [7:0] nxt_cnt;

  always_comb
  begin
    if (cond)
      nxt_cnt = (cnt_ff >= limit) ? limit : cnt_ff + `MTHD_CNT_ONE;
    else if (clear_mode)
      nxt_cnt = `MTHD_RST_CNT;
    else if (cnt_ff != `MTHD_RST_CNT)
      nxt_cnt = cnt_ff - `MTHD_CNT_ONE;
    else
      nxt_cnt = `MTHD_RST_CNT;
  end

  // A zero limit triggers on the first qualifying sample
  assign trig = step && cond && (nxt_cnt >= limit);

  always_ff @(posedge clk)
  begin
    if (reset)
      cnt_ff <= `MTHD_RST_CNT;
    else if (step)
      cnt_ff <= nxt_cnt;
  end

endmodule : mthd_debounce

/* mthd_host_model.sv */
// Host processor model that drives the register port of the threshold detector
`timescale 1ns/1ps

module mthd_host_model (
  input  wire logic       clk,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd
);
  initial
  begin
    addr  = 8'h00;
    wdata = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // One strobe cycle per access; released address and data lines show the inverse, never a stale value
  task automatic access(input logic is_wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr  = a;
    wdata = d;
    wr    = is_wr;
    rd    = ~is_wr;
    @(posedge clk);
    #1;
    wr    = 1'b0;
    rd    = 1'b0;
    addr  = ~a;
    wdata = ~d;
  endtask : access
endmodule : mthd_host_model

/* mag_threshold_event_detector_tb.sv */
// Self-checking testbench of the magnetic threshold event detector
`timescale 1ns/1ps
`include "mthd_defines.svh"

module mag_threshold_event_detector_tb;
  logic                   clk;
  logic                   reset;
  logic [7:0]             addr;
  logic [7:0]             wdata;
  logic                   wr;
  logic                   rd;
  logic [7:0]             rdata;
  logic                   stb;
  logic [2:0][15:0]       mag;
  logic [2:0][15:0]       offs;
  logic                   raw;
  logic [1:0]             mode;
  mthd_pkg::mthd_cfg_type cfg;
  logic                   oth_one;
  logic                   oth_two;
  logic                   irq_one;
  logic                   irq_two;
  logic                   flag;
  logic [7:0]             exp_q[$];
  logic [7:0]             d;
  logic [7:0]             init_v[7];
  integer                 failures;
  integer                 checked;
  integer                 seed;
  integer                 i;

  mthd_host_model host_u (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

  mthd_detector dut_u (
    .CLK(clk), .RESET(reset), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .SAMPLE_STROBE(stb), .MAG_SAMPLE(mag),
    .MAG_OFFSET(offs), .RAW_OUTPUT(raw), .SENSOR_MODE(mode), .CFG(cfg),
    .IRQ_ONE_OTHER(oth_one), .IRQ_TWO_OTHER(oth_two), .IRQ_PIN_ONE(irq_one),
    .IRQ_PIN_TWO(irq_two), .EVENT_ACTIVE_FLAG(flag)
  );

  always #12.5 clk = ~clk;

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Read data lands at the taking edge; compare against the oldest note
  always @(posedge clk)
  begin
    if (rd === 1'b1)
    begin
      #2;
      check("read data", rdata, exp_q.pop_front());
    end
  end

  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.access(1'b0, a, 8'h00);
  endtask : rd_exp

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    host_u.access(1'b1, a, v);
  endtask : wr_reg

  // Z always above its threshold; Z stays disabled so it must never count
  task automatic stb_chk(input logic [15:0] x, input logic [15:0] y, input logic e);
    @(posedge clk);
    #1;
    mag = {16'h01F4, y, x};
    stb = 1'b1;
    @(posedge clk);
    #1;
    stb = 1'b0;
    mag = ~{16'h01F4, y, x};
    check("event flag", {7'h00, flag}, {7'h00, e});
  endtask : stb_chk

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  initial
  begin
    repeat (8000) @(posedge clk);
    failures = failures + 1;
    $display("wrong value run time expected end seen hang");
    give_verdict();
  end

  initial
  begin
    clk = 1'b0; reset = 1'b1; stb = 1'b0; mag = '0; offs = '0; raw = 1'b0;
    mode = `MTHD_MODE_MAG; oth_one = 1'b0; oth_two = 1'b0;
    cfg = '{latch_en: 1'b0, or_sel: 1'b1, axis_en: 3'b001, int_en: 1'b1, int_route: 1'b1};
    failures = 0; checked = 0; seed = 32'h596a;
    init_v = '{8'h00, 8'h64, 8'h00, 8'h0A, 8'h00, 8'h0A, 8'h03};
    repeat (4) @(posedge clk);
    #1;
    reset = 1'b0;
    for (i = 0; i < 8; i++)
      rd_exp(`MTHD_ADDR_SRC + i[7:0], 8'h00);
    rd_exp(8'h60, 8'h00);
    for (i = 1; i < 8; i++)
    begin
      d = 8'($random(seed));
      wr_reg(`MTHD_ADDR_SRC + i[7:0], d);
      rd_exp(`MTHD_ADDR_SRC + i[7:0], (i == 3 || i == 5) ? (d & 8'h7F) : d);
    end
    wr_reg(`MTHD_ADDR_SRC, 8'hFF);
    rd_exp(`MTHD_ADDR_SRC, 8'h00);
    for (i = 0; i < 7; i++)
      wr_reg(`MTHD_ADDR_X_HI + i[7:0], init_v[i]);
    stb_chk(16'h00C8, 16'h0000, 1'b0);
    stb_chk(16'h00C8, 16'h0000, 1'b0);
    stb_chk(16'h00C8, 16'h0000, 1'b1);
    stb_chk(16'h00C8, 16'h0000, 1'b1);
    check("irq pins", {6'h00, irq_two, irq_one}, 8'h01);
    cfg.int_route = 1'b0;
    oth_one = 1'b1;
    @(posedge clk);
    #1;
    check("irq pins", {6'h00, irq_two, irq_one}, 8'h03);
    cfg.int_en = 1'b0;
    oth_one = 1'b0;
    @(posedge clk);
    #1;
    check("irq pins", {6'h00, irq_two, irq_one}, 8'h00);
    rd_exp(`MTHD_ADDR_SRC, 8'h82);
    stb_chk(16'hFF38, 16'h0000, 1'b1);
    rd_exp(`MTHD_ADDR_SRC, 8'h83);
    stb_chk(16'h0032, 16'h0000, 1'b0);
    stb_chk(16'h00C8, 16'h0000, 1'b1);
    wr_reg(`MTHD_ADDR_X_HI, 8'h80);
    stb_chk(16'h0032, 16'h0000, 1'b0);
    stb_chk(16'h00C8, 16'h0000, 1'b0);
    stb_chk(16'h00C8, 16'h0000, 1'b0);
    stb_chk(16'h00C8, 16'h0000, 1'b1);
    wr_reg(`MTHD_ADDR_COUNT, 8'h00);
    offs[0] = 16'h0064;
    stb_chk(16'h0096, 16'h0000, 1'b0);
    raw = 1'b1;
    stb_chk(16'h0096, 16'h0000, 1'b1);
    cfg.or_sel = 1'b0;
    cfg.axis_en = 3'b011;
    stb_chk(16'h0032, 16'h0005, 1'b1);
    stb_chk(16'h0032, 16'h0014, 1'b0);
    stb_chk(16'h0064, 16'h000A, 1'b1);
    cfg.or_sel = 1'b1;
    cfg.axis_en = 3'b001;
    cfg.latch_en = 1'b1;
    stb_chk(16'h00C8, 16'h0000, 1'b1);
    stb_chk(16'h0032, 16'h0000, 1'b1);
    rd_exp(`MTHD_ADDR_SRC, 8'h82);
    check("event flag", {7'h00, flag}, 8'h00);
    cfg.latch_en = 1'b0;
    wr_reg(`MTHD_ADDR_COUNT, 8'h01);
    mode = `MTHD_MODE_HYB;
    stb_chk(16'h00C8, 16'h0000, 1'b0);
    stb_chk(16'h00C8, 16'h0000, 1'b1);
    mode = 2'h0;
    stb_chk(16'h0032, 16'h0000, 1'b1);
    repeat (2) @(posedge clk);
    give_verdict();
  end
endmodule : mag_threshold_event_detector_tb
